// file: verilog/eeprom_pkg.sv
/*
  Shared constants for the serial EEPROM target and its bus controller:
  memory geometry, address byte layout, bit counter codes and timing counts.
  Assumes the system clock of both ends runs at CLK_PERIOD_NS.
*/
package eeprom_pkg;
  // system clock
  localparam int CLK_PERIOD_NS = 100;

  // power-up to ready and internal write cycle, in milliseconds and cycles
  localparam int POWER_UP_MS = 1;
  localparam int POWER_UP_CYCLES = POWER_UP_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLES = WRITE_CYCLE_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  // bus clock rates; the controller runs the standard rate
  localparam int SCL_STD_KHZ = 100;
  localparam int SCL_FAST_KHZ = 400;
  localparam int SCL_QUARTER_CYCLES = (1_000_000 / SCL_STD_KHZ) / CLK_PERIOD_NS / 4;

  // memory geometry
  localparam int PAGE_COUNT = 32;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = PAGE_COUNT * PAGE_BYTES;
  localparam int ADDR_W = 9;
  localparam int OFFS_W = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // address byte: fixed type code, two select bits, high address bit, direction
  localparam logic [3:0] DEV_TYPE_ID = 4'ha;
  localparam int ID_LO_POS = 4;
  localparam int SEL_LO_POS = 2;
  localparam int A8_POS = 1;
  localparam int RW_POS = 0;
  localparam logic RW_READ = 1'b1;

  // bit counter: 0..7 data, 8 acknowledge, 15 before the first bit
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] PRE_BIT = 4'hf;
endpackage : eeprom_pkg

// file: verilog/i2c_link_if.sv
/*
  Two-wire link between the bus controller and the EEPROM target.
  Each end gives value and enable per open-drain pin; the wire levels are
  resolved here with pull-ups, so neither end ever drives a high level.
*/
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl_out;
  logic scl_oe;
  logic ctl_sda_out;
  logic ctl_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // pulled up unless an enabled driver pulls low
  assign scl = ~(scl_oe & ~scl_out);
  assign sda = ~((ctl_sda_oe & ~ctl_sda_out) | (dev_sda_oe & ~dev_sda_out));

  modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport controller (input scl, input sda, output scl_out, output scl_oe,
                      output ctl_sda_out, output ctl_sda_oe);
endinterface : i2c_link_if
`default_nettype wire

// file: verilog/word_buffer.sv
/*
  Small first-in first-out buffer with valid and ready on both sides.
  Assumes one clock; in_ready falls when every slot is taken.
*/
`timescale 1ns/1ps
`default_nettype none
module word_buffer
  import eeprom_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PW-1:0]               head;
    logic [PW-1:0]               tail;
    logic [PW:0]                 count;
  } buf_t;

  buf_t s;
  buf_t n;

  assign in_ready = s.count != (PW+1)'(DEPTH);
  assign out_valid = s.count != '0;
  assign out_data = s.slot[s.head];

  // pointers wrap at DEPTH, which need not be a power of two
  always_comb begin
    n = s;
    if (in_valid && in_ready) begin
      n.slot[s.tail] = in_data;
      n.tail = (s.tail == PW'(DEPTH - 1)) ? '0 : s.tail + 1'b1;
    end
    if (out_valid && out_ready) begin
      n.head = (s.head == PW'(DEPTH - 1)) ? '0 : s.head + 1'b1;
    end
    n.count = s.count + (PW+1)'(in_valid && in_ready) - (PW+1)'(out_valid && out_ready);
    if (rst) begin
      n = '0;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end
endmodule : word_buffer
`default_nettype wire

// file: verilog/i2c_eeprom_controller.sv
/*
  Bus controller end: makes SCL by dividing its own clock, frames START and
  STOP, writes pages, reads with or without an address phase. Read bytes
  leave through a two-entry buffer; a full buffer holds SCL low.
  Assumes the target does not stretch the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_eeprom_controller
  import eeprom_pkg::*;
#(
  parameter int POWER_UP_WAIT = POWER_UP_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          rst,
  i2c_link_if.controller     link,
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire logic          cmd_read,
  input  wire logic          cmd_set_addr,
  input  wire logic [1:0]    cmd_select,
  input  wire logic [8:0]    cmd_addr,
  input  wire logic [7:0]    cmd_len,
  input  wire logic          wr_valid,
  output logic               wr_ready,
  input  wire logic [7:0]    wr_data,
  output logic               rd_valid,
  input  wire logic          rd_ready,
  output logic      [7:0]    rd_data,
  output logic               done,
  output logic               not_acknowledged,
  output logic               ready
);
  typedef enum {C_IDLE, C_START, C_NEXT, C_BYTE, C_STOP} cstate_t;
  typedef enum {K_DEV, K_WADDR, K_DEVR, K_DATA} kind_t;

  typedef struct packed {
    logic [2:0]       sda_sync;
    logic             sda_f;
    logic [CNT_W-1:0] pu_cnt;
    logic             ready;
    cstate_t          st;
    kind_t            kind;
    logic [1:0]       phase;
    logic [7:0]       qcnt;
    logic [3:0]       bitn;
    logic [7:0]       shreg;
    logic             samp;
    logic             rd_mode;
    logic             set_addr;
    logic [1:0]       sel;
    logic [8:0]       addr;
    logic [7:0]       len;
    logic             scl_low;
    logic             sda_low;
    logic             done;
    logic             nack;
  } ctl_t;

  ctl_t c;
  ctl_t n;
  logic       push;
  logic       buf_in_ready;
  logic       go;
  logic [7:0] load;
  logic       rx;
  logic       last;
  logic       tick;

  word_buffer #(.WIDTH(8), .DEPTH(2)) u_rd_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (c.shreg),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // open-drain drive: enable means pull low [R13] [R14]
  assign link.scl_out = 1'b0;
  assign link.scl_oe = c.scl_low;
  assign link.ctl_sda_out = 1'b0;
  assign link.ctl_sda_oe = c.sda_low;
  assign cmd_ready = c.st == C_IDLE && c.ready;
  assign done = c.done;
  assign not_acknowledged = c.nack;
  assign ready = c.ready;

  // quarter-period sequencer; sda only moves in phases 1..3, never on the scl edge
  always_comb begin
    n = c;
    n.done = 1'b0;
    push = 1'b0;
    wr_ready = 1'b0;
    go = 1'b0;
    load = 8'h00;
    rx = c.kind == K_DATA && c.rd_mode;
    last = c.len == 8'h01;
    tick = c.qcnt == 8'(SCL_QUARTER_CYCLES - 1); // standard rate, within limit [R4]
    n.sda_sync = {c.sda_sync[1:0], link.sda};
    if (c.sda_sync[1] == c.sda_sync[2]) n.sda_f = c.sda_sync[2];
    if (!c.ready) begin
      if (c.pu_cnt == CNT_W'(POWER_UP_WAIT - 1)) n.ready = 1'b1; // no command early [R7]
      else n.pu_cnt = c.pu_cnt + 1'b1;
    end
    n.qcnt = tick ? 8'h00 : c.qcnt + 8'h01;
    case (c.st)
      C_IDLE: begin
        n.scl_low = 1'b0;
        n.sda_low = 1'b0;
        if (cmd_valid && c.ready) begin
          n.rd_mode = cmd_read;
          n.set_addr = cmd_set_addr;
          n.sel = cmd_select;
          n.addr = cmd_addr;
          n.len = cmd_len;
          n.kind = K_DEV;
          n.nack = 1'b0;
          n.st = C_START;
          n.phase = 2'h0;
          n.qcnt = 8'h00;
        end
      end
      C_START, C_STOP: begin
        n.scl_low = c.phase < 2'h2; // [R13]
        if (c.phase != 2'h0)
          n.sda_low = (c.st == C_START) ? (c.phase == 2'h3) : (c.phase != 2'h3);
        if (tick) begin
          n.phase = c.phase + 2'h1;
          if (c.phase == 2'h3) begin
            n.st = (c.st == C_START) ? C_NEXT : C_IDLE;
            n.done = c.st == C_STOP;
          end
        end
      end
      C_NEXT: begin
        // scl held low while waiting for write data or buffer room
        n.scl_low = 1'b1;
        case (c.kind)
          K_DEV: begin
            go = 1'b1;
            load = {DEV_TYPE_ID, c.sel, c.addr[8], c.rd_mode && !c.set_addr}; // [R15]
          end
          K_WADDR: begin
            go = 1'b1;
            load = c.addr[7:0];
          end
          K_DEVR: begin
            go = 1'b1;
            load = {DEV_TYPE_ID, c.sel, c.addr[8], RW_READ}; // [R15]
          end
          default: begin
            go = c.rd_mode ? buf_in_ready : wr_valid;
            wr_ready = !c.rd_mode && wr_valid;
            load = c.rd_mode ? ERASED_BYTE : wr_data;
          end
        endcase
        if (go) begin
          n.shreg = load;
          n.st = C_BYTE;
          n.bitn = 4'h0;
          n.phase = 2'h0;
          n.qcnt = 8'h00;
        end
      end
      C_BYTE: begin
        n.scl_low = c.phase < 2'h2;
        if (c.phase != 2'h0)
          n.sda_low = (c.bitn == ACK_BIT) ? (rx && !last) : (!rx && !c.shreg[7]); // [R14]
        if (tick) begin
          n.phase = c.phase + 2'h1;
          if (c.phase == 2'h2) n.samp = c.sda_f;
          if (c.phase == 2'h3) begin
            if (c.bitn != ACK_BIT) begin
              n.bitn = c.bitn + 4'h1;
              n.shreg = {c.shreg[6:0], c.samp};
            end else begin
              n.st = C_NEXT;
              if (c.kind == K_DATA) begin
                push = rx;
                n.len = c.len - 8'h01;
                if (last) n.st = C_STOP;
              end
              if (!rx && c.samp) begin
                n.nack = 1'b1;
                n.st = C_STOP;
              end else if (c.kind == K_DEV) begin
                n.kind = (c.rd_mode && !c.set_addr) ? K_DATA : K_WADDR;
              end else if (c.kind == K_WADDR) begin
                n.kind = c.rd_mode ? K_DEVR : K_DATA;
                if (c.rd_mode) n.st = C_START;
              end else if (c.kind == K_DEVR) begin
                n.kind = K_DATA;
              end
            end
          end
        end
      end
      default: n.st = C_IDLE;
    endcase
    if (rst) begin
      n = '0;
      n.sda_sync = 3'h7;
      n.sda_f = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    c <= n;
  end
endmodule : i2c_eeprom_controller
`default_nettype wire

// file: verilog/i2c_eeprom_target.sv
/*
  Target end of a 4-kilobit two-wire serial EEPROM: address match, page
  write buffer committed in one timed write cycle, auto-increment reads,
  write protect and power-up delay. rst stands for the power-on detector.
  Assumes the bus controller makes SCL and every START and STOP, and that
  undriven strap pins are held low by the surroundings.
*/
// Rules this block is written against
// (R1) array is 32 pages of 16 bytes
// (R2) buffer 1..16 bytes, commit in one cycle
// (R3) reads shift out and auto-increment address
// (R4) works at 100 kHz and 400 kHz
// (R5) select pins must match address byte bits
// (R6) power-on reset, then standby
// (R7) no commands before power-up delay ends
// (R8) pulses up to 100 ns are ignored
// (R9) sda driven open drain only
// (R10) sample on scl rise, change after fall
// (R11) undriven select pins read low; the block samples the pins as given, with no pull-down of its own
// (R12) write protect high blocks all writes
// (R13) controller makes clock, start and stop
// (R14) zero pulls sda low, one releases
// (R15) address byte: 1010, three bits, direction
// (R16) page write wraps the low four bits
// (R17) write protect latched before first data byte
// (R18) no acknowledge while write cycle runs
// (R19) address counter kept across transactions
`timescale 1ns/1ps
`default_nettype none
module i2c_eeprom_target
  import eeprom_pkg::*;
#(
  parameter int POWER_UP_DELAY = POWER_UP_CYCLES,
  parameter int WRITE_TIME     = WRITE_CYCLES
) (
  input  wire logic      clk,
  input  wire logic      rst,
  i2c_link_if.device     link,
  input  wire logic      device_select_bit1,
  input  wire logic      device_select_bit2,
  input  wire logic      write_protect,
  output logic           ready,
  output logic           write_busy
);
  typedef enum {D_IDLE, D_ADDR, D_WADDR, D_WDATA, D_READ} dstate_t;

  typedef struct packed {
    logic [2:0]                      scl_sync;
    logic [2:0]                      sda_sync;
    logic [2:0]                      wp_sync;
    logic [2:0][1:0]                 sel_sync;
    logic                            scl_f;
    logic                            sda_f;
    logic                            wp_f;
    logic [1:0]                      sel_f;
    logic [CNT_W-1:0]                pu_cnt;
    logic                            ready;
    logic [CNT_W-1:0]                wr_cnt;
    logic                            busy;
    dstate_t                         st;
    logic [3:0]                      bitn;
    logic [7:0]                      shreg;
    logic                            drive_low;
    logic                            ack_seen;
    logic                            a8;
    logic [ADDR_W-1:0]               ptr;
    logic                            wp_armed;
    logic                            wp_hit;
    logic [PAGE_BYTES-1:0][7:0]      pbuf;
    logic [PAGE_BYTES-1:0]           pmask;
  } dev_t;

  dev_t s;
  dev_t n;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       commit;
  logic [7:0] mem_rd;

  // nonvolatile array, byte index = {page, offset}
  logic [7:0] mem [MEM_BYTES];

  // delivered erased; the array is not touched by the power-on reset
  initial begin
    for (int i = 0; i < MEM_BYTES; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

  assign mem_rd = mem[s.ptr];

  // open drain: only ever pulls low, releases for a one [R9] [R14]
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = s.drive_low;
  assign ready = s.ready;
  assign write_busy = s.busy;

  always_comb begin
    n = s;
    commit = 1'b0;

    // three-flop sampling; a level counts once stages two and three agree,
    // so a one-cycle (100 ns) glitch never reaches the edge logic [R8]
    n.scl_sync = {s.scl_sync[1:0], link.scl};
    n.sda_sync = {s.sda_sync[1:0], link.sda};
    n.wp_sync = {s.wp_sync[1:0], write_protect};
    n.sel_sync = {s.sel_sync[1:0], {device_select_bit2, device_select_bit1}}; // [R11]
    if (s.scl_sync[1] == s.scl_sync[2]) n.scl_f = s.scl_sync[2]; // [R8]
    if (s.sda_sync[1] == s.sda_sync[2]) n.sda_f = s.sda_sync[2]; // [R8]
    if (s.wp_sync[1] == s.wp_sync[2]) n.wp_f = s.wp_sync[2];
    if (s.sel_sync[1] == s.sel_sync[2]) n.sel_f = s.sel_sync[2];

    // 10 MHz sampling leaves several cycles per phase even at 400 kHz [R4]
    scl_rise = n.scl_f && !s.scl_f;
    scl_fall = !n.scl_f && s.scl_f;
    start_seen = s.scl_f && n.scl_f && s.sda_f && !n.sda_f;
    stop_seen = s.scl_f && n.scl_f && !s.sda_f && n.sda_f;

    // standby only after the power-up delay has run out [R6] [R7]
    if (!s.ready) begin
      if (s.pu_cnt == CNT_W'(POWER_UP_DELAY - 1)) n.ready = 1'b1;
      else n.pu_cnt = s.pu_cnt + 1'b1;
    end

    // internal write cycle timer
    if (s.busy) begin
      if (s.wr_cnt == CNT_W'(WRITE_TIME - 1)) n.busy = 1'b0;
      else n.wr_cnt = s.wr_cnt + 1'b1;
    end

    if (stop_seen) begin
      // stop after accepted data starts the single page commit [R2] [R12]
      if (s.st == D_WDATA && s.pmask != '0 && !s.wp_hit) begin
        commit = 1'b1;
        n.busy = 1'b1;
        n.wr_cnt = '0;
      end
      n.st = D_IDLE;
      n.drive_low = 1'b0;
    end else if (start_seen) begin
      // a start before power-up is ready is simply not answered [R7]
      n.st = s.ready ? D_ADDR : D_IDLE;
      n.bitn = PRE_BIT;
      n.drive_low = 1'b0;
    end else if (s.st != D_IDLE) begin
      if (scl_rise) begin
        // incoming bits taken on the rising edge [R10]
        if (s.bitn == ACK_BIT) n.ack_seen = !s.sda_f;
        else if (s.st != D_READ) n.shreg = {s.shreg[6:0], s.sda_f}; // [R10]
      end
      if (scl_fall) begin
        // the fall that ends a start leaves bitn at PRE_BIT + 1 = 0
        n.bitn = (s.bitn == ACK_BIT) ? 4'h0 : s.bitn + 4'h1;
        n.drive_low = 1'b0;
        if (s.bitn == LAST_DATA_BIT) begin
          case (s.st)
            D_ADDR: begin
              // match type code and strapped pins; busy answers nothing [R5] [R15] [R18]
              if (s.shreg[7:ID_LO_POS] == DEV_TYPE_ID &&
                  s.shreg[A8_POS+2:SEL_LO_POS] == s.sel_f && !s.busy) begin
                n.drive_low = 1'b1;
                n.a8 = s.shreg[A8_POS];
                n.st = (s.shreg[RW_POS] == RW_READ) ? D_READ : D_WADDR;
              end else begin
                n.st = D_IDLE;
              end
            end
            D_WADDR: begin
              n.ptr = {s.a8, s.shreg};
              n.pmask = '0;
              n.wp_armed = 1'b1;
              n.wp_hit = 1'b0;
              n.drive_low = 1'b1;
              n.st = D_WDATA;
            end
            D_WDATA: begin
              if (s.wp_hit) begin
                n.st = D_IDLE; // protected: data byte not acknowledged [R12] [R17]
              end else begin
                n.pbuf[s.ptr[OFFS_W-1:0]] = s.shreg; // [R2]
                n.pmask[s.ptr[OFFS_W-1:0]] = 1'b1;
                n.ptr[OFFS_W-1:0] = s.ptr[OFFS_W-1:0] + 4'h1; // wraps in the page [R16]
                n.drive_low = 1'b1;
              end
            end
            default: ;
          endcase
        end else if (s.bitn == ACK_BIT) begin
          // last fall before the first data byte strobes write protect [R17]
          if (s.wp_armed) begin
            n.wp_armed = 1'b0;
            n.wp_hit = s.wp_f; // [R12]
          end
          if (s.st == D_READ) begin
            // our own ack reads back as acknowledged, so the first byte follows
            if (s.ack_seen) begin
              n.shreg = mem_rd;
              n.drive_low = !mem_rd[7]; // [R10]
              n.ptr = s.ptr + 1'b1; // whole-array wrap, kept afterwards [R3] [R19]
            end else begin
              n.st = D_IDLE;
            end
          end
        end else if (s.st == D_READ && s.bitn != PRE_BIT) begin
          // next outgoing bit changes only after the fall [R10]
          n.shreg = {s.shreg[6:0], 1'b0};
          n.drive_low = !s.shreg[6]; // [R3]
        end
      end
    end

    // power-on detector: below the trigger level everything is held [R6]
    if (rst) begin
      n = '0;
      n.scl_sync = 3'h7;
      n.sda_sync = 3'h7;
      n.scl_f = 1'b1;
      n.sda_f = 1'b1;
      commit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  // all buffered bytes of one page land in the same cycle [R1] [R2]
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (s.pmask[i]) mem[{s.ptr[ADDR_W-1:OFFS_W], OFFS_W'(i)}] <= s.pbuf[i];
      end
    end
  end
endmodule : i2c_eeprom_target
`default_nettype wire

// file: tb/eeprom_link_monitor.sv
/*
  Link checker: open-drain levels, SCL timing and the target's quiet rules.
  Assumes the link signals and the target's ready and write_busy flags.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_link_monitor #(
  parameter int WRITE_TIME = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic ready,
  input wire logic write_busy
);
  logic        last_scl;
  logic [7:0]  run;
  logic [15:0] busy_run;

  // run lengths of each scl level and of the write cycle; the scl run saturates so idle stays quiet
  always_ff @(posedge clk) begin
    last_scl <= scl;
    if (rst) begin
      // idle bus after reset counts as a long high level, so the first START is not short
      run      <= 8'hff;
      busy_run <= 16'h0000;
    end else begin
      run      <= (scl != last_scl) ? 8'h01 : run + {7'h00, run != 8'hff};
      busy_run <= write_busy ? busy_run + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_fall; $fell(scl); endsequence
  sequence s_rise; $rose(scl); endsequence

  property p_dev_od; dev_sda_oe |-> !dev_sda_out; endproperty
  a_dev_od: assert property (p_dev_od)
    else $error("target drove sda high");
  property p_sda_low; dev_sda_oe |-> !sda; endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("sda not low while target pulls it");
  property p_scl_low; scl_oe |-> !scl_out && !scl; endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("scl not pulled low by controller");
  property p_dev_change; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
  a_dev_change: assert property (p_dev_change)
    else $error("target changed sda while scl high");
  property p_high; s_fall |-> run >= 8'h28; endproperty
  a_high: assert property (p_high)
    else $error("scl high period too short");
  property p_low; s_rise |-> run >= 8'h2f; endproperty
  a_low: assert property (p_low)
    else $error("scl low period too short");
  property p_quiet; !ready || write_busy |-> !dev_sda_oe; endproperty
  a_quiet: assert property (p_quiet)
    else $error("target answered while not ready or busy");
  property p_busy; $fell(write_busy) |-> busy_run >= WRITE_TIME - 1 && busy_run <= WRITE_TIME + 1;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write cycle length wrong");
endmodule : eeprom_link_monitor
`default_nettype wire

// file: tb/serial_eeprom_i2c_target_test.sv
/*
  Bench joining the EEPROM target and its bus controller over one link.
  Assumes both ends share clk and rst; straps come from the random source.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_i2c_target_test;
  import eeprom_pkg::*;
  localparam int WT = 3000;
  logic        clk, rst, wp, t_ready, busy, c_ready, done, nack;
  logic        cmd_valid, cmd_ready, cmd_read, cmd_set_addr, wr_valid, wr_ready;
  logic        rd_valid, rd_ready, s_wtk, s_rtk, s_done;
  logic [1:0]  cmd_select, strap;
  logic [8:0]  cmd_addr;
  logic [7:0]  cmd_len, wr_data, rd_data, s_rd;
  logic [7:0]  mem [MEM_BYTES];
  logic [7:0]  wq [$];
  logic [7:0]  rq [$];
  logic [31:0] rs = 32'h0000_002c;
  int          ptr, failures, tests_run;

  i2c_link_if link ();
  i2c_eeprom_target #(.POWER_UP_DELAY(20), .WRITE_TIME(WT)) i_i2c_eeprom_target (
    .clk(clk), .rst(rst), .link(link.device), .device_select_bit1(strap[0]),
    .device_select_bit2(strap[1]), .write_protect(wp), .ready(t_ready), .write_busy(busy));
  i2c_eeprom_controller #(.POWER_UP_WAIT(20)) i_i2c_eeprom_controller (
    .clk(clk), .rst(rst), .link(link.controller), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_set_addr(cmd_set_addr),
    .cmd_select(cmd_select), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .done(done), .not_acknowledged(nack), .ready(c_ready));
  eeprom_link_monitor #(.WRITE_TIME(WT)) i_eeprom_link_monitor (
    .clk(clk), .rst(rst), .scl_out(link.scl_out), .scl_oe(link.scl_oe),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl),
    .sda(link.sda), .ready(t_ready), .write_busy(busy));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // handshakes as seen at the edge, so process order cannot matter
  always @(posedge clk) begin
    s_wtk  <= wr_valid && wr_ready;
    s_rtk  <= rd_valid && rd_ready;
    s_rd   <= rd_data;
    s_done <= done;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // every wait is bounded; running out ends the run as a failure
  task automatic bound(inout int t, input int lim);
    tick();
    t++;
    if (t > lim) begin
      failures++;
      results();
    end
  endtask : bound

  // one command: offer it, feed write bytes, gather read bytes, wait for done
  task automatic xfer(input logic rd, input logic sa, input logic [1:0] sel,
                      input logic [8:0] a, input int n, input logic stall);
    int t;
    t  = 0;
    rq = {};
    while (cmd_ready !== 1'b1) bound(t, 2000);
    {cmd_read, cmd_set_addr, cmd_select, cmd_addr, cmd_len} = {rd, sa, sel, a, 8'(n)};
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    t = 0;
    while (s_done !== 1'b1) begin
      wr_valid = wq.size() > 0;
      wr_data  = wr_valid ? wq[0] : 8'h00;
      rd_ready = !(stall && t < 4000); // early stall ends before the second byte arrives, so the buffer never fills and scl never waits for room
      bound(t, 60000);
      if (s_wtk === 1'b1) void'(wq.pop_front());
      if (s_rtk === 1'b1) rq.push_back(s_rd);
    end
    wr_valid = 1'b0;
    rd_ready = 1'b1;
    wq = {};
  endtask : xfer

  task automatic do_write(input logic [8:0] a, input int n, input logic want_nack);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'(xs());
      wq.push_back(b);
      if (!want_nack) mem[{a[8:4], 4'(a[3:0] + i)}] = b;
    end
    xfer(1'b0, 1'b1, strap, a, n, 1'b0);
    chk({7'h00, nack}, {7'h00, want_nack});
    if (!want_nack) ptr = {a[8:4], 4'(a[3:0] + n)};
  endtask : do_write

  task automatic do_read(input logic sa, input logic [1:0] sel, input logic [8:0] a,
                         input int n, input logic stall, input logic want_nack);
    if (sa) ptr = a;
    xfer(1'b1, sa, sel, a, n, stall);
    chk({7'h00, nack}, {7'h00, want_nack});
    if (!want_nack) begin
      chk(8'(rq.size()), 8'(n));
      foreach (rq[i]) begin
        chk(rq[i], mem[ptr]);
        ptr = (ptr + 1) % MEM_BYTES;
      end
    end
  endtask : do_read

  // main sequence
  initial begin
    int t;
    {cmd_valid, cmd_read, cmd_set_addr, cmd_select, cmd_addr, cmd_len} = '0;
    {wr_valid, wr_data, wp} = '0;
    rd_ready = 1'b1;
    rst      = 1'b1;
    strap    = 2'(xs());
    ptr      = 0;
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    repeat (3) tick();
    rst = 1'b0;
    chk({7'h00, t_ready}, 8'h00);
    chk({7'h00, c_ready}, 8'h00);
    repeat (10) tick();
    chk({7'h00, t_ready}, 8'h00);
    repeat (15) tick();
    chk({7'h00, t_ready}, 8'h01);
    chk({7'h00, c_ready}, 8'h01);
    do_write(9'h03e, 17, 1'b0);
    chk({7'h00, busy}, 8'h01);
    do_write(9'h000, 1, 1'b1);
    t = 0;
    while (busy !== 1'b0) bound(t, 5000);
    do_read(1'b1, strap, 9'h03c, 6, 1'b1, 1'b0);
    do_read(1'b0, strap, 9'h000, 2, 1'b0, 1'b0);
    wp = 1'b1;
    do_write(9'h1f0, 1, 1'b1);
    wp = 1'b0;
    chk({7'h00, busy}, 8'h00);
    do_read(1'b1, strap, 9'h1f0, 1, 1'b0, 1'b0);
    // brown-out in mid-run: state and address counter cleared, array kept
    rst = 1'b1;
    repeat (3) tick();
    rst = 1'b0;
    ptr = 0;
    chk({7'h00, t_ready}, 8'h00);
    chk({7'h00, busy}, 8'h00);
    for (int s = 0; s < 4; s++) do_read(1'b0, 2'(s), 9'h000, 1, 1'b0, 2'(s) != strap);
    results();
  end
endmodule : serial_eeprom_i2c_target_test
`default_nettype wire
